// ===== gate_fault_defines.svh
`ifndef GATE_FAULT_DEFINES_SVH
`define GATE_FAULT_DEFINES_SVH

`define CLK_PERIOD_NS 10
// power-on reset hold time
`define POR_TIME_MS 150
`define POR_CYCLES ((`POR_TIME_MS * 1000000) / `CLK_PERIOD_NS)
// short pulse filter: suppress below, always pass above
`define SPF_MIN_NS 625
`define SPF_MAX_NS 750
// filter length: more than 625 ns, not beyond 750 ns
`define SPF_CYCLES ((`SPF_MIN_NS / `CLK_PERIOD_NS) + 1)
// inputs low for more than 9 us before the latch may clear
`define CLEAR_TIME_US 9
`define CLEAR_CYCLES (((`CLEAR_TIME_US * 1000) / `CLK_PERIOD_NS) + 1)
// plain defaults for the analog-set times
`define DEAD_TIME_NS 1000
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_TIME_NS 3000
`define BLANK_CYCLES ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== gate_fault_pkg.sv
package gate_fault_pkg;
  typedef enum logic [1:0] {
    GATE_OFF,
    GATE_WAIT,
    GATE_ON
  } gate_state_e;
endpackage

// ===== half_bridge_gate_fault_logic.sv
`timescale 1ns/1ps
`include "gate_fault_defines.svh"

module half_bridge_gate_fault_logic #(
  parameter int PorCycles = `POR_CYCLES,
  parameter int FilterCycles = `SPF_CYCLES,
  parameter int ClearCycles = `CLEAR_CYCLES,
  parameter int DeadCycles = `DEAD_CYCLES,
  parameter int BlankCycles = `BLANK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic upperSwitchIn,
  input wire logic lowerSwitchIn,
  input wire logic external_shutdown_in,
  input wire logic upperDesatIn,
  input wire logic lowerDesatIn,
  input wire logic supplyUndervoltageIn,
  output logic upper_gate_on_drive,
  output logic upper_gate_off_drive,
  output logic lower_gate_on_drive,
  output logic lower_gate_off_drive,
  output logic fault_indicator_out,
  output logic fault_indicator_alias,
  output logic faultIndicatorOe,
  output logic porDone
);

  localparam int PorW = $clog2(PorCycles + 1);
  localparam int FiltW = $clog2(FilterCycles + 1);
  localparam int ClrW = $clog2(ClearCycles + 1);
  localparam int DeadW = $clog2(DeadCycles + 1);
  localparam int BlankW = $clog2(BlankCycles + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: all pins come from outside the clock domain

  // bit order: 0 upper, 1 lower, 2 shutdown, 3 upper desat, 4 lower desat, 5 uv
  logic [5:0] pinRaw;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;

  assign pinRaw = {supplyUndervoltageIn, lowerDesatIn, upperDesatIn,
                   external_shutdown_in, lowerSwitchIn, upperSwitchIn};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // shutdown resets high so a floating pin reads inactive
      sync1_q <= 6'h04;
      sync2_q <= 6'h04;
    end else if (clkEn) begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
    end
  end

  logic shutdownActive;
  logic uvActive;
  assign shutdownActive = ~sync2_q[2];
  assign uvActive = sync2_q[5];

  ////////////////////////////////////////////////////////////////////////////////
  // power-on reset timer

  logic [PorW-1:0] porCnt_q;
  logic porDone_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      porCnt_q <= '0;
      porDone_q <= 1'b0;
    end else if (clkEn) begin
      if (porCnt_q == PorW'(PorCycles - 1)) begin
        porDone_q <= 1'b1;
      end else begin
        porCnt_q <= porCnt_q + PorW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // short pulse filter, one per switching input

  logic [1:0] filt_q;
  logic [FiltW-1:0] filtCnt_q [2];

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : gFilter
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          filt_q[ch] <= 1'b0;
          filtCnt_q[ch] <= '0;
        end else if (clkEn) begin
          // a level must hold FilterCycles before it is accepted
          if (sync2_q[ch] == filt_q[ch]) begin
            filtCnt_q[ch] <= '0;
          end else if (filtCnt_q[ch] == FiltW'(FilterCycles - 1)) begin
            filt_q[ch] <= sync2_q[ch];
            filtCnt_q[ch] <= '0;
          end else begin
            filtCnt_q[ch] <= filtCnt_q[ch] + FiltW'(1);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // fault latch

  logic fault_q;
  logic [ClrW-1:0] clrCnt_q;
  logic desatTrip;
  logic faultNow;
  logic inputsLow;

  assign faultNow = uvActive | shutdownActive | desatTrip;
  // raw synchronised levels: the quiet time is measured on the pins
  assign inputsLow = ~sync2_q[0] & ~sync2_q[1];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clrCnt_q <= '0;
    end else if (clkEn) begin
      if (!inputsLow || faultNow) begin
        clrCnt_q <= '0;
      end else if (clrCnt_q != ClrW'(ClearCycles)) begin
        clrCnt_q <= clrCnt_q + ClrW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else if (clkEn) begin
      if (!porDone_q) begin
        // only latch at release when a fault really stands
        fault_q <= 1'b0;
      end else if (faultNow) begin
        fault_q <= 1'b1;
      end else if (clrCnt_q == ClrW'(ClearCycles)) begin
        fault_q <= 1'b0;
      end
    end
  end

  logic blocked;
  // commands are treated inactive during reset and while faulted
  assign blocked = ~porDone_q | fault_q | faultNow;

  ////////////////////////////////////////////////////////////////////////////////
  // interlock and gate state per channel

  gate_fault_pkg::gate_state_e st_q [2];
  logic [DeadW-1:0] deadCnt_q [2];
  logic [BlankW-1:0] blankCnt_q [2];
  logic [1:0] isOn;
  logic [1:0] desatHit;

  assign isOn[0] = (st_q[0] == gate_fault_pkg::GATE_ON);
  assign isOn[1] = (st_q[1] == gate_fault_pkg::GATE_ON);
  assign desatTrip = |desatHit;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : gChannel
      logic cmd;
      logic otherOn;
      assign cmd = filt_q[ch] & ~filt_q[1-ch] & ~blocked;
      assign otherOn = isOn[1-ch];
      // blanking restarts each turn-on since the count clears in off
      assign desatHit[ch] = isOn[ch] && (blankCnt_q[ch] == BlankW'(BlankCycles))
                            && sync2_q[3+ch];

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          st_q[ch] <= gate_fault_pkg::GATE_OFF;
          deadCnt_q[ch] <= '0;
          blankCnt_q[ch] <= '0;
        end else if (clkEn) begin
          case (st_q[ch])
            gate_fault_pkg::GATE_OFF: begin
              blankCnt_q[ch] <= '0;
              // dead time runs from the other gate's turn-off, so a
              // controller gap overlaps it instead of adding
              if (otherOn) begin
                deadCnt_q[ch] <= '0;
              end else if (deadCnt_q[ch] != DeadW'(DeadCycles)) begin
                deadCnt_q[ch] <= deadCnt_q[ch] + DeadW'(1);
              end
              if (cmd && !otherOn) begin
                st_q[ch] <= gate_fault_pkg::GATE_WAIT;
              end
            end
            gate_fault_pkg::GATE_WAIT: begin
              if (!cmd || otherOn) begin
                st_q[ch] <= gate_fault_pkg::GATE_OFF;
              end else if (deadCnt_q[ch] == DeadW'(DeadCycles)) begin
                st_q[ch] <= gate_fault_pkg::GATE_ON;
              end else begin
                deadCnt_q[ch] <= deadCnt_q[ch] + DeadW'(1);
              end
            end
            gate_fault_pkg::GATE_ON: begin
              deadCnt_q[ch] <= '0;
              if (blankCnt_q[ch] != BlankW'(BlankCycles)) begin
                blankCnt_q[ch] <= blankCnt_q[ch] + BlankW'(1);
              end
              if (!cmd || desatTrip) begin
                st_q[ch] <= gate_fault_pkg::GATE_OFF;
              end
            end
            default: begin
              st_q[ch] <= gate_fault_pkg::GATE_OFF;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      upper_gate_on_drive <= 1'b0;
      upper_gate_off_drive <= 1'b1;
      lower_gate_on_drive <= 1'b0;
      lower_gate_off_drive <= 1'b1;
    end else if (clkEn) begin
      // on-drive only from the on state, off-drive its complement
      upper_gate_on_drive <= isOn[0] & ~blocked;
      upper_gate_off_drive <= ~(isOn[0] & ~blocked);
      lower_gate_on_drive <= isOn[1] & ~blocked;
      lower_gate_off_drive <= ~(isOn[1] & ~blocked);
    end
  end

  // error line released during reset: safe reading with the pull-up
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_indicator_out <= 1'b0;
      faultIndicatorOe <= 1'b0;
      fault_indicator_alias <= 1'b1;
      porDone <= 1'b0;
    end else if (clkEn) begin
      fault_indicator_out <= 1'b0;
      faultIndicatorOe <= porDone_q & ~fault_q & ~faultNow;
      fault_indicator_alias <= ~porDone_q | fault_q | faultNow;
      porDone <= porDone_q;
    end
  end

endmodule // half_bridge_gate_fault_logic

// ===== half_bridge_gate_fault_logic_props.sv
`timescale 1ns/1ps
module half_bridge_gate_fault_logic_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic upperSwitchIn,
  input wire logic lowerSwitchIn,
  input wire logic external_shutdown_in,
  input wire logic upperDesatIn,
  input wire logic lowerDesatIn,
  input wire logic supplyUndervoltageIn,
  input wire logic upper_gate_on_drive,
  input wire logic upper_gate_off_drive,
  input wire logic lower_gate_on_drive,
  input wire logic lower_gate_off_drive,
  input wire logic fault_indicator_out,
  input wire logic fault_indicator_alias,
  input wire logic faultIndicatorOe,
  input wire logic porDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_noShoot; !(upper_gate_on_drive && lower_gate_on_drive); endproperty
  a_noShoot: assert property (p_noShoot) else $error("both gates on");
  property p_pair;
    (upper_gate_on_drive ^ upper_gate_off_drive) && (lower_gate_on_drive ^ lower_gate_off_drive);
  endproperty
  a_pair: assert property (p_pair) else $error("on and off drive clash");
  property p_porOff; !porDone |-> !upper_gate_on_drive && !lower_gate_on_drive; endproperty
  a_porOff: assert property (p_porOff) else $error("gate on before reset done");
  property p_ocData; faultIndicatorOe |-> fault_indicator_out == 1'b0; endproperty
  a_ocData: assert property (p_ocData) else $error("fault line driven high");
  property p_aliasOe; fault_indicator_alias == !faultIndicatorOe; endproperty
  a_aliasOe: assert property (p_aliasOe) else $error("alias and line disagree");
  property p_faultOff;
    !faultIndicatorOe [*2] |-> !upper_gate_on_drive && !lower_gate_on_drive;
  endproperty
  a_faultOff: assert property (p_faultOff) else $error("gate on while fault");
  property p_shutdown; porDone && clkEn && $fell(external_shutdown_in) |-> ##[1:6] !faultIndicatorOe;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not latched");
  property p_uv; porDone && clkEn && $rose(supplyUndervoltageIn) |-> ##[1:6] !faultIndicatorOe;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not latched");
  property p_filter; $rose(upper_gate_on_drive) |-> $past(upperSwitchIn, 62); endproperty
  a_filter: assert property (p_filter) else $error("short pulse passed");
endmodule // half_bridge_gate_fault_logic_props
bind half_bridge_gate_fault_logic half_bridge_gate_fault_logic_props u_props (.ref_clk, .reset,
  .clkEn, .upperSwitchIn, .lowerSwitchIn, .external_shutdown_in, .upperDesatIn, .lowerDesatIn,
  .supplyUndervoltageIn, .upper_gate_on_drive, .upper_gate_off_drive, .lower_gate_on_drive,
  .lower_gate_off_drive, .fault_indicator_out, .fault_indicator_alias, .faultIndicatorOe,
  .porDone);

// ===== half_bridge_gate_fault_logic_test.sv
`timescale 1ns/1ps
module half_bridge_gate_fault_logic_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic external_shutdown_in = 1'b1;
  logic upperDesatIn = 1'b0;
  logic lowerDesatIn = 1'b0;
  logic supplyUndervoltageIn = 1'b0;
  logic upperSwitchIn, lowerSwitchIn, faultLine, upSeen;
  logic upper_gate_on_drive, upper_gate_off_drive, lower_gate_on_drive, lower_gate_off_drive;
  logic fault_indicator_out, fault_indicator_alias, faultIndicatorOe, porDone;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  half_bridge_gate_fault_logic #(.PorCycles(20), .DeadCycles(4), .BlankCycles(8))
    u_half_bridge_gate_fault_logic (.ref_clk, .reset, .clkEn, .upperSwitchIn, .lowerSwitchIn,
    .external_shutdown_in, .upperDesatIn, .lowerDesatIn, .supplyUndervoltageIn,
    .upper_gate_on_drive, .upper_gate_off_drive, .lower_gate_on_drive, .lower_gate_off_drive,
    .fault_indicator_out, .fault_indicator_alias, .faultIndicatorOe, .porDone);
  pwm_controller_model u_pwm_controller_model (.ref_clk, .porDone, .fault_indicator_out,
    .faultIndicatorOe, .upperSwitchIn, .lowerSwitchIn, .faultLine);
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (upper_gate_on_drive === 1'b1) upSeen <= 1'b1;
    // whole run needs about 4000 cycles
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic drv(input logic u, input logic l, input int n);
    u_pwm_controller_model.drive(u, l, n);
  endtask
  // 801 low cycles is under 9 us, 952 is over it
  task automatic clear_fault;
    drv(1'b0, 1'b0, 800);
    chk("held", 1'b1, faultLine);
    drv(1'b0, 1'b0, 150);
    chk("cleared", 1'b0, faultLine);
  endtask
  task automatic t_por;
    chk("gate in reset", 1'b0, upper_gate_on_drive | lower_gate_on_drive);
    chk("line in reset", 1'b1, faultLine);
    for (int i = 0; i < 100 && porDone !== 1'b1; i++) cyc(1);
    cyc(2);
    chk("line after reset", 1'b0, faultLine);
    $display("test por done");
  endtask
  task automatic t_filter;
    upSeen = 1'b0;
    drv(1'b1, 1'b0, 58);
    drv(1'b0, 1'b0, 100);
    chk("short pulse", 1'b0, upSeen);
    drv(1'b1, 1'b0, 90);
    chk("long pulse", 1'b1, upper_gate_on_drive);
    drv(1'b0, 1'b1, 90);
    chk("inverse lower", 1'b1, lower_gate_on_drive);
    chk("inverse upper", 1'b0, upper_gate_on_drive);
    drv(1'b0, 1'b0, 20);
    $display("test filter done");
  endtask
  task automatic t_shutdown;
    drv(1'b1, 1'b0, 90);
    external_shutdown_in = 1'b0;
    cyc(8);
    chk("shutdown line", 1'b1, faultLine);
    chk("shutdown gate", 1'b0, upper_gate_on_drive);
    drv(1'b0, 1'b1, 90);
    chk("ignored cmd", 1'b0, lower_gate_on_drive);
    external_shutdown_in = 1'b1;
    clear_fault();
    drv(1'b1, 1'b0, 90);
    chk("after clear", 1'b1, upper_gate_on_drive);
    $display("test shutdown done");
  endtask
  task automatic t_uv;
    supplyUndervoltageIn = 1'b1;
    cyc(8);
    chk("uv line", 1'b1, faultLine);
    chk("uv gate", 1'b0, upper_gate_on_drive);
    supplyUndervoltageIn = 1'b0;
    clear_fault();
    $display("test uv done");
  endtask
  task automatic t_desat;
    upperDesatIn = 1'b1;
    cyc(20);
    chk("desat while off", 1'b0, faultLine);
    upperDesatIn = 1'b0;
    drv(1'b1, 1'b0, 0);
    for (int i = 0; i < 200 && upper_gate_on_drive !== 1'b1; i++) cyc(1);
    upperDesatIn = 1'b1;
    cyc(2);
    upperDesatIn = 1'b0;
    cyc(10);
    chk("blanked desat", 1'b0, faultLine);
    upperDesatIn = 1'b1;
    cyc(8);
    chk("desat line", 1'b1, faultLine);
    chk("desat gate", 1'b0, upper_gate_on_drive);
    upperDesatIn = 1'b0;
    clear_fault();
    $display("test desat done");
  endtask
  // clock enable low must freeze every stage, the filter and gate state included
  task automatic t_freeze;
    drv(1'b1, 1'b0, 90);
    chk("freeze start", 1'b1, upper_gate_on_drive);
    clkEn = 1'b0;
    drv(1'b0, 1'b0, 100);
    chk("frozen gate", 1'b1, upper_gate_on_drive);
    clkEn = 1'b1;
    cyc(90);
    chk("thawed gate", 1'b0, upper_gate_on_drive);
    $display("test freeze done");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    reset = 1'b0;
    t_por();
    t_filter();
    t_shutdown();
    t_uv();
    t_desat();
    t_freeze();
    end_of_test();
  end
endmodule // half_bridge_gate_fault_logic_test

// ===== pwm_controller_model.sv
`timescale 1ns/1ps
module pwm_controller_model (
  input wire logic ref_clk,
  input wire logic porDone,
  input wire logic fault_indicator_out,
  input wire logic faultIndicatorOe,
  output logic upperSwitchIn,
  output logic lowerSwitchIn,
  output wire logic faultLine
);
  // pull-up wins whenever the device lets go, so a broken wire reads as error
  assign faultLine = faultIndicatorOe ? fault_indicator_out : 1'b1;
  initial begin
    upperSwitchIn = 1'b0;
    lowerSwitchIn = 1'b0;
  end
  task automatic drive(input logic u, input logic l, input int n);
    @(posedge ref_clk);
    #1;
    upperSwitchIn = u && porDone;
    lowerSwitchIn = l && porDone;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
endmodule // pwm_controller_model
